// ===== rtl/srp_pkg.sv
package srp_pkg;

  // Register byte offsets on the APB window
  localparam logic [11:0] REG_ROM_DATA = 12'h000;
  localparam logic [11:0] REG_ROM_ADDR = 12'h004;
  localparam logic [11:0] REG_PI_DATA  = 12'h008;
  localparam logic [11:0] REG_PI_ADDR  = 12'h00c;

  // Field positions
  localparam int ROM_FLAG_BIT = 31;
  localparam int PI_FLAG_BIT  = 15;
  localparam int PI_OFF_LSB   = 1;
  localparam int PI_RO_BIT    = 7;

  // Serial store instructions
  localparam logic [7:0] OPC_READ  = 8'h03;
  localparam logic [7:0] OPC_WRITE = 8'h02;
  localparam logic [7:0] OPC_WLEN  = 8'h06;
  localparam logic [7:0] OPC_POLL  = 8'h05;

  // Transaction lengths in serial clocks
  localparam logic [5:0] LEN_CMD  = 6'h08;
  localparam logic [5:0] LEN_STAT = 6'h10;
  localparam logic [5:0] LEN_DATA = 6'h38;

  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCK_PERIOD_NS = 400;
  localparam int CLK_FREQ_MHZ  = 20;
  localparam int POLL_TIME_US  = 2000;
  localparam logic [2:0] SCK_HALF_M1 =
    3'((SCK_PERIOD_NS / CLK_PERIOD_NS) / 2 - 1);
  localparam logic [15:0] POLL_CYC = 16'(POLL_TIME_US * CLK_FREQ_MHZ);

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_GAP   = 4'b0010,
    S_SHIFT = 4'b0100,
    S_WAIT  = 4'b1000
  } srp_fsm_t;

  typedef enum logic [1:0] {
    OP_WLEN  = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ  = 2'h2,
    OP_POLL  = 2'h3
  } srp_op_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } srp_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } srp_apb_rsp_t;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic mosi;
  } srp_spi_out_t;

  typedef struct packed {
    srp_fsm_t     fsm;
    srp_op_t      op;
    srp_apb_rsp_t rsp;
    srp_spi_out_t spi;
    logic [31:0]  rom_data;
    logic [15:0]  rom_addr;
    logic         rom_flag;
    logic         rom_pend;
    logic [31:0]  pi_data;
    logic [6:0]   pi_off;
    logic         pi_flag;
    logic         pi_pend;
    logic         who;
    logic [55:0]  tx;
    logic [31:0]  rx;
    logic [5:0]   bitcnt;
    logic [5:0]   len;
    logic [2:0]   div;
    logic [15:0]  poll;
    logic [1:0]   miso_sync;
  } srp_state_t;

  localparam srp_state_t ST_RESET = '{
    fsm: S_IDLE, op: OP_WLEN, spi: '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0},
    default: '0};

  // Byte 0 travels first on the wire, so words are byte swapped
  function automatic logic [31:0] srp_swap(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : srp_swap

endpackage : srp_pkg

// ===== rtl/srp_top.sv
`timescale 1ns/1ns
module srp_top #(
  parameter logic [15:0] P_POLL_CYC = srp_pkg::POLL_CYC
) (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_reset_n,
  // APB slave
  input  wire srp_pkg::srp_apb_req_t i_apb,
  output      srp_pkg::srp_apb_rsp_t o_apb,
  // Serial store pins
  output      srp_pkg::srp_spi_out_t o_spi,
  input  wire logic                  i_miso
);
  import srp_pkg::*;

  srp_state_t st_q;
  srp_state_t st_d;
  logic       shift_done;
  logic       acc_take;
  logic       wr_hit;

  // Last falling serial edge of the current transaction
  assign shift_done = (st_q.fsm == S_SHIFT) && (st_q.div == SCK_HALF_M1) &&
                      st_q.spi.sck && (st_q.bitcnt == st_q.len - 6'h01);
  assign acc_take   = i_apb.psel & i_apb.penable & ~st_q.rsp.pready;
  assign wr_hit     = i_apb.psel & i_apb.penable & st_q.rsp.pready &
                      i_apb.pwrite;

  // Next-state logic for bus, registers and serial sequencer
  always_comb begin
    logic [55:0] tx_new;
    logic [15:0] cur_addr;
    logic [31:0] rd_val;
    logic        hit;
    tx_new   = '0;
    cur_addr = '0;
    rd_val   = '0;
    hit      = 1'b1;
    st_d     = st_q;
    st_d.miso_sync   = {st_q.miso_sync[0], i_miso};
    st_d.rsp.pready  = 1'b0;

    // low address bits forced to zero
    // product offset lands inside the first 256 bytes
    if (st_q.who) begin
      cur_addr = {8'h00, st_q.pi_off[6:1], 2'b00};
    end else begin
      cur_addr = st_q.rom_addr;
    end

    unique case (st_q.fsm)
      S_IDLE: begin
        // arbitrate pending requests one at a time
        if (st_q.rom_pend) begin
          st_d.who = 1'b0;
          st_d.op  = st_q.rom_flag ? OP_WLEN : OP_READ;
          st_d.fsm = S_GAP;
          st_d.div = '0;
        end else if (st_q.pi_pend) begin
          st_d.who = 1'b1;
          st_d.op  = st_q.pi_flag ? OP_WLEN : OP_READ;
          st_d.fsm = S_GAP;
          st_d.div = '0;
        end
      end
      S_GAP: begin
        // Chip select high for half a serial period, then launch
        st_d.div = st_q.div + 3'h1;
        if (st_q.div == SCK_HALF_M1) begin
          // instruction first, address after, MSB first
          // read and write opcodes, byte 0 leads
          unique case (st_q.op)
            OP_WLEN: begin
              tx_new   = {OPC_WLEN, 48'h0};
              st_d.len = LEN_CMD;
            end
            OP_WRITE: begin
              tx_new   = {OPC_WRITE, cur_addr,
                          srp_swap(st_q.who ? st_q.pi_data
                                            : st_q.rom_data)};
              st_d.len = LEN_DATA;
            end
            OP_READ: begin
              tx_new   = {OPC_READ, cur_addr, 32'h0};
              st_d.len = LEN_DATA;
            end
            OP_POLL: begin
              tx_new   = {OPC_POLL, 48'h0};
              st_d.len = LEN_STAT;
            end
          endcase
          st_d.tx       = tx_new;
          st_d.spi.mosi = tx_new[55];
          st_d.spi.cs_n = 1'b0;
          st_d.spi.sck  = 1'b0;
          st_d.bitcnt   = '0;
          st_d.div      = '0;
          st_d.fsm      = S_SHIFT;
        end
      end
      S_SHIFT: begin
        st_d.div = (st_q.div == SCK_HALF_M1) ? 3'h0 : st_q.div + 3'h1;
        if (st_q.div == SCK_HALF_M1) begin
          if (!st_q.spi.sck) begin
            // Rising edge samples the synchronised input
            st_d.spi.sck = 1'b1;
            st_d.rx      = {st_q.rx[30:0], st_q.miso_sync[1]};
          end else if (shift_done) begin
            st_d.spi.sck  = 1'b0;
            st_d.spi.cs_n = 1'b1;
            st_d.spi.mosi = 1'b0;
            st_d.div      = '0;
            unique case (st_q.op)
              OP_WLEN: begin
                // write enable ends, then the write follows
                st_d.op  = OP_WRITE;
                st_d.fsm = S_GAP;
              end
              OP_WRITE: begin
                // first status poll right after the write
                st_d.op  = OP_POLL;
                st_d.fsm = S_GAP;
              end
              OP_READ: begin
                if (st_q.who) begin
                  st_d.pi_data = srp_swap(st_q.rx);
                  st_d.pi_flag = 1'b1;
                  st_d.pi_pend = 1'b0;
                end else begin
                  st_d.rom_data = srp_swap(st_q.rx);
                  st_d.rom_flag = 1'b1;
                  st_d.rom_pend = 1'b0;
                end
                st_d.fsm = S_IDLE;
              end
              OP_POLL: begin
                // busy bit 0 decides wait or finish
                if (st_q.rx[0]) begin
                  st_d.poll = '0;
                  st_d.fsm  = S_WAIT;
                end else begin
                  if (st_q.who) begin
                    st_d.pi_flag = 1'b0;
                    st_d.pi_pend = 1'b0;
                  end else begin
                    st_d.rom_flag = 1'b0;
                    st_d.rom_pend = 1'b0;
                  end
                  st_d.fsm = S_IDLE;
                end
              end
            endcase
          end else begin
            // Falling edge presents the next bit
            st_d.spi.sck  = 1'b0;
            st_d.bitcnt   = st_q.bitcnt + 6'h01;
            st_d.tx       = {st_q.tx[54:0], 1'b0};
            st_d.spi.mosi = st_q.tx[54];
          end
        end
      end
      S_WAIT: begin
        st_d.poll = st_q.poll + 16'h0001;
        if (st_q.poll == P_POLL_CYC - 16'h0001) begin
          st_d.op  = OP_POLL;
          st_d.div = '0;
          st_d.fsm = S_GAP;
        end
      end
    endcase

    unique case (i_apb.paddr)
      REG_ROM_DATA: rd_val = st_q.rom_data;
      REG_ROM_ADDR: rd_val = {st_q.rom_flag, 15'h0, st_q.rom_addr};
      REG_PI_DATA:  rd_val = st_q.pi_data;
      REG_PI_ADDR:  rd_val = {16'h0, st_q.pi_flag, 7'h0, st_q.pi_off,
                              1'b0};
      default:      hit    = 1'b0;
    endcase

    // Access phase answered one cycle later from a flip-flop
    if (acc_take) begin
      st_d.rsp.pready  = 1'b1;
      st_d.rsp.pslverr = ~hit;
      st_d.rsp.prdata  = hit ? rd_val : 32'h0;
    end

    // Writes land on the edge where pready is seen high
    if (wr_hit) begin
      unique case (i_apb.paddr)
        REG_ROM_DATA: st_d.rom_data = i_apb.pwdata;
        REG_PI_DATA:  st_d.pi_data  = i_apb.pwdata;
        REG_ROM_ADDR: begin
          // flag value selects read or write
          // full 16-bit address, no region limit
          if (!st_q.rom_pend) begin
            st_d.rom_addr = {i_apb.pwdata[15:2], 2'b00};
            st_d.rom_flag = i_apb.pwdata[ROM_FLAG_BIT];
            st_d.rom_pend = 1'b1;
          end
        end
        REG_PI_ADDR: begin
          // flag zero starts a product read
          // flag one with offset bit 7 set starts a product write
          if (!st_q.pi_pend) begin
            st_d.pi_off  = {i_apb.pwdata[7:2], 1'b0};
            st_d.pi_flag = i_apb.pwdata[PI_FLAG_BIT];
            // refused write clears flag at once
            if (i_apb.pwdata[PI_FLAG_BIT] && !i_apb.pwdata[PI_RO_BIT]) begin
              st_d.pi_flag = 1'b0;
            end else begin
              st_d.pi_pend = 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // reset leaves everything idle, chip select high
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_apb = st_q.rsp;
  assign o_spi = st_q.spi;

  // Assertions
  a_idle_cs_high: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (st_q.fsm != S_SHIFT) |-> st_q.spi.cs_n)
    else $error("chip select low outside a transaction");

  a_single_txn: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (st_q.fsm == S_SHIFT) |-> (st_q.rom_pend | st_q.pi_pend))
    else $error("transaction running with no request");

  a_wlen_then_wr: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (shift_done && st_q.op == OP_WLEN) |=>
      (st_q.fsm == S_GAP && st_q.op == OP_WRITE && st_q.spi.cs_n))
    else $error("write enable not followed by write");

  a_poll_after_wr: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (shift_done && st_q.op == OP_WRITE) |=>
      (st_q.fsm == S_GAP && st_q.op == OP_POLL))
    else $error("no status poll after write");

  a_poll_wait: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (st_q.fsm == S_WAIT && st_q.poll != P_POLL_CYC - 16'h0001) |=>
      (st_q.fsm == S_WAIT && st_q.poll == $past(st_q.poll) + 16'h0001))
    else $error("status poll interval cut short");

  a_rd_done_flag: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (shift_done && st_q.op == OP_READ && !st_q.who) |=>
      (st_q.rom_flag && !st_q.rom_pend &&
       st_q.rom_data == srp_swap($past(st_q.rx))))
    else $error("general read did not deliver word and flag");

  a_pi_rd_flag: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (shift_done && st_q.op == OP_READ && st_q.who) |=>
      (st_q.pi_flag && !st_q.pi_pend))
    else $error("product read did not raise flag");

  a_ro_refused: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (wr_hit && i_apb.paddr == REG_PI_ADDR && !st_q.pi_pend &&
     i_apb.pwdata[PI_FLAG_BIT] && !i_apb.pwdata[PI_RO_BIT]) |=>
      (!st_q.pi_flag && !st_q.pi_pend))
    else $error("read-only product write not refused");

  a_wr_done_clear: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (shift_done && st_q.op == OP_POLL && !st_q.rx[0]) |=>
      (st_q.fsm == S_IDLE && !(st_q.who ? st_q.pi_flag : st_q.rom_flag)))
    else $error("write completion did not clear flag");

  a_pi_wr_clear: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (shift_done && st_q.op == OP_POLL && !st_q.rx[0] && st_q.who) |=>
      (!st_q.pi_flag && !st_q.pi_pend))
    else $error("product write completion did not clear flag");

  a_pi_region: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (st_q.fsm == S_SHIFT && st_q.who && st_q.bitcnt == 6'h00 &&
     st_q.op inside {OP_READ, OP_WRITE}) |->
      (st_q.tx[47:40] == 8'h00 && (st_q.op == OP_READ || st_q.tx[39])))
    else $error("product access outside its writable region");

  a_addr_aligned: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (st_q.fsm == S_SHIFT && st_q.op inside {OP_READ, OP_WRITE} &&
     st_q.bitcnt == 6'h00) |-> (st_q.tx[33:32] == 2'b00))
    else $error("serial address not word aligned");

  a_bit_count: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (st_q.fsm == S_SHIFT) |-> (st_q.bitcnt < st_q.len))
    else $error("serial bit count overran length");

  c_rom_read: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    shift_done && st_q.op == OP_READ && !st_q.who);
  c_rom_write: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    shift_done && st_q.op == OP_POLL && !st_q.rx[0] && !st_q.who);
  c_poll_busy: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    shift_done && st_q.op == OP_POLL && st_q.rx[0]);
  c_pi_write: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    shift_done && st_q.op == OP_POLL && !st_q.rx[0] && st_q.who);
  c_pi_refused: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    wr_hit && i_apb.paddr == REG_PI_ADDR && i_apb.pwdata[PI_FLAG_BIT] &&
    !i_apb.pwdata[PI_RO_BIT]);

endmodule : srp_top

// ===== verif/srp_rom_model.sv
`timescale 1ns/1ns
module srp_rom_model (
  // Serial store pins
  input  wire logic i_sck,
  input  wire logic i_cs_n,
  input  wire logic i_mosi,
  output logic      o_miso
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  wbuf [0:3];
  logic [7:0]  sh;
  logic [7:0]  opc;
  logic [15:0] adr;
  logic        wel;
  int          nb;
  int          busy;

  // Preload a known pattern, idle state
  initial begin
    foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5a;
    o_miso = 1'b0;
    wel = 1'b0;
    nb = 0;
    busy = 0;
  end

  // Frame start clears the bit count
  always @(negedge i_cs_n) nb = 0;

  // Frame end: enable latch, commit write, age busy status
  always @(posedge i_cs_n) begin
    o_miso = ~o_miso;
    if (opc == 8'h06 && nb == 8) wel = 1'b1;
    if (opc == 8'h02 && nb == 56 && wel) begin
      for (int k = 0; k < 4; k++) mem[16'(adr + 16'(k))] = wbuf[k];
      wel = 1'b0;
      busy = 2;
    end
    if (opc == 8'h05 && nb == 16 && busy > 0) busy--;
  end

  // Shift in on rising clock
  always @(posedge i_sck) begin
    if (!i_cs_n) begin
      sh = {sh[6:0], i_mosi};
      nb++;
      if (nb == 8) opc = sh;
      if (nb == 16) adr[15:8] = sh;
      if (nb == 24) adr[7:0] = sh;
      if (opc == 8'h02 && nb > 24 && nb % 8 == 0) wbuf[(nb - 32) / 8] = sh;
    end
  end

  // Shift out on falling clock, else a changing pattern
  always @(negedge i_sck) begin
    if (opc == 8'h03 && nb >= 24 && nb < 56)
      o_miso = mem[16'(adr + 16'((nb - 24) / 8))][7 - (nb - 24) % 8];
    else if (opc == 8'h05 && nb >= 8 && nb < 16)
      o_miso = (nb == 15) ? (busy > 0) : 1'b0;
    else
      o_miso = ~o_miso;
  end
endmodule : srp_rom_model

// ===== verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import srp_pkg::*;
  logic         i_clk;
  logic         i_reset_n;
  srp_apb_req_t apb;
  srp_apb_rsp_t rsp;
  srp_spi_out_t spi;
  logic         miso;
  logic         err;
  logic [31:0]  seed;
  logic [31:0]  rd;
  logic [31:0]  d;
  logic [15:0]  a;
  logic [31:0]  shadow [logic [15:0]];
  int           n_mismatch;
  int           num_checks;
  int           n_cs;
  int           c0;

  srp_top #(.P_POLL_CYC(16'h0014)) u_srp_top (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_apb(apb), .o_apb(rsp),
    .o_spi(spi), .i_miso(miso));
  srp_rom_model u_srp_rom_model (
    .i_sck(spi.sck), .i_cs_n(spi.cs_n), .i_mosi(spi.mosi), .o_miso(miso));

  // Clock
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // Count serial frames
  always @(negedge spi.cs_n) n_cs++;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Expected word: written value or preload pattern
  function automatic logic [31:0] expv(input logic [15:0] ad);
    logic [31:0] w;
    for (int i = 0; i < 4; i++) w[8*i +: 8] = 8'(ad + 16'(i)) ^ 8'h5a;
    if (shadow.exists(ad)) w = shadow[ad];
    return w;
  endfunction : expv

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // One APB transfer, waits for pready
  task automatic xfer(input logic w, input logic [11:0] ad,
                      input logic [31:0] wd, output logic [31:0] r);
    int k;
    @(posedge i_clk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ad, pwdata: wd};
    @(posedge i_clk);
    apb.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 40);
    if (k >= 40) chk(32'h0, 32'h1);
    r = rsp.prdata;
    err = rsp.pslverr;
    apb <= '0;
  endtask : xfer

  task automatic wait_flag(input logic [11:0] ad, input int b,
                           input logic v);
    int k;
    k = 0;
    do begin
      xfer(1'b0, ad, 32'h0, rd);
      k++;
    end while (rd[b] !== v && k < 600);
    chk({31'h0, rd[b]}, {31'h0, v});
  endtask : wait_flag

  task automatic rom_rd(input logic [15:0] ad);
    xfer(1'b1, REG_ROM_ADDR, {16'h0, ad}, rd);
    xfer(1'b0, REG_ROM_ADDR, 32'h0, rd);
    chk(rd, {16'h0, ad[15:2], 2'b00});
    wait_flag(REG_ROM_ADDR, ROM_FLAG_BIT, 1'b1);
    xfer(1'b0, REG_ROM_DATA, 32'h0, rd);
    chk(rd, expv({ad[15:2], 2'b00}));
  endtask : rom_rd

  task automatic rom_wr(input logic [15:0] ad, input logic [31:0] wd);
    c0 = n_cs;
    xfer(1'b1, REG_ROM_DATA, wd, rd);
    xfer(1'b1, REG_ROM_ADDR, {1'b1, 15'h0, ad}, rd);
    xfer(1'b0, REG_ROM_ADDR, 32'h0, rd);
    chk(rd, {1'b1, 15'h0, ad});
    wait_flag(REG_ROM_ADDR, ROM_FLAG_BIT, 1'b0);
    chk(32'(n_cs - c0), 32'h5);
    shadow[ad] = wd;
  endtask : rom_wr

  task automatic pi_rd(input logic [7:0] off);
    xfer(1'b1, REG_PI_ADDR, {24'h0, off}, rd);
    wait_flag(REG_PI_ADDR, PI_FLAG_BIT, 1'b1);
    xfer(1'b0, REG_PI_DATA, 32'h0, rd);
    chk(rd, expv({8'h0, off}));
  endtask : pi_rd

  task automatic pi_wr(input logic [7:0] off, input logic [31:0] wd);
    c0 = n_cs;
    xfer(1'b1, REG_PI_DATA, wd, rd);
    xfer(1'b1, REG_PI_ADDR, {16'h0, 1'b1, 7'h0, off}, rd);
    if (off < 8'h80) begin
      xfer(1'b0, REG_PI_ADDR, 32'h0, rd);
      chk({31'h0, rd[PI_FLAG_BIT]}, 32'h0);
      chk(32'(n_cs - c0), 32'h0);
    end else begin
      wait_flag(REG_PI_ADDR, PI_FLAG_BIT, 1'b0);
      chk(32'(n_cs - c0), 32'h5);
      shadow[{8'h0, off}] = wd;
    end
  endtask : pi_wr

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  // Watchdog
  initial begin
    repeat (40000) @(posedge i_clk);
    n_mismatch++;
    close_out();
  end

  // Main sequence
  initial begin
    apb = '0;
    i_reset_n = 1'b0;
    seed = 32'h6953;
    n_cs = 0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'b1;
    chk({31'h0, spi.cs_n}, 32'h1);
    for (int r = 0; r < 4; r++) begin
      xfer(1'b0, 12'(4 * r), 32'h0, rd);
      chk(rd, 32'h0);
    end
    xfer(1'b1, 12'h010, 32'hffffffff, rd);
    chk({31'h0, err}, 32'h1);
    // Random general reads, all beyond the product area
    repeat (3) begin
      seed = lfsr(seed);
      rom_rd(seed[15:0]);
    end
    seed = lfsr(seed);
    a = {seed[15:2], 2'b00};
    rom_wr(a, lfsr(seed));
    rom_rd(a);
    // General interface may write the read-only product bytes
    rom_wr(16'h0010, 32'h0bad_cafe);
    pi_rd(8'h10);
    pi_rd(8'h40);
    pi_wr(8'h7c, 32'hdeadbeef);
    pi_rd(8'h7c);
    seed = lfsr(seed);
    pi_wr(8'hfc, seed);
    pi_rd(8'hfc);
    // Both interfaces launched together share the serial store
    xfer(1'b1, REG_ROM_ADDR, 32'h0000_0104, rd);
    xfer(1'b1, REG_PI_ADDR, 32'h0000_0080, rd);
    wait_flag(REG_ROM_ADDR, ROM_FLAG_BIT, 1'b1);
    wait_flag(REG_PI_ADDR, PI_FLAG_BIT, 1'b1);
    xfer(1'b0, REG_ROM_DATA, 32'h0, rd);
    chk(rd, expv(16'h0104));
    xfer(1'b0, REG_PI_DATA, 32'h0, rd);
    chk(rd, expv(16'h0080));
    close_out();
  end
endmodule : tb_top
